//--- pkg/dpm_map.svh
// Constants shared by the converter control ends
`ifndef DPM_MAP_SVH
`define DPM_MAP_SVH

// ****************************************
// Sample path
// ****************************************
`define DPM_DATA_W 14
`define DPM_DATA_MSB 13
`define DPM_FIFO_DEPTH 16

// ****************************************
// Serial frame: 1 direction bit, 7 address bits, 8 data bits
// ****************************************
`define DPM_HEAD_LAST 4'h7
`define DPM_FRAME_LAST 4'hF
`define DPM_FRAME_RD 15
`define DPM_SREG_CTRL 7'h00
`define DPM_SREG_STAT 7'h01
`define DPM_SCTRL_DEF 8'h00
`define DPM_SCTRL_PD 0
`define DPM_SCTRL_TWOS 1
`define DPM_SCTRL_SE 2

// ****************************************
// Host APB map and serial clock divider
// ****************************************
`define DPM_APB_PINS 12'h000
`define DPM_APB_CMD 12'h004
`define DPM_APB_STAT 12'h008
`define DPM_APB_SAMPLE 12'h00C
`define DPM_PINS_MODE 0
`define DPM_PINS_FMT 1
`define DPM_PINS_CLK 2
`define DPM_PINS_SLEEP 3
`define DPM_PINS_RST 4'h1
`define DPM_SCLK_HALF 4'h7

`endif

//--- pkg/dpm_pkg.sv
// Types for the converter control ends
`include "dpm_map.svh"
package dpm_pkg;

  typedef enum logic [2:0] {DS_IDLE, DS_HEAD, DS_WDATA, DS_RDATA, DS_END} dpm_dser_t;
  typedef enum logic {HS_IDLE, HS_RUN} dpm_hser_t;

  typedef struct packed {
    logic [1:0] modeSync;
    logic [2:0] sclkSync;
    logic [1:0] csbSync;
    logic [1:0] sdioSync;
    logic modePrev;
    dpm_dser_t ser;
    logic [3:0] bitCnt;
    logic [14:0] shiftIn;
    logic [7:0] outShift;
    logic rdOe;
    logic rdBit;
    logic [7:0] ctrl;
    logic [`DPM_DATA_MSB:0] trueCode;
    logic [`DPM_DATA_MSB:0] compCode;
  } dpm_dev_state_t;

  typedef struct packed {
    logic [3:0] pins;
    dpm_hser_t ser;
    logic [15:0] cmd;
    logic isRead;
    logic [3:0] div;
    logic [3:0] bitCnt;
    logic sclk;
    logic csb;
    logic sdoBit;
    logic sdoOe;
    logic [1:0] sdioSync;
    logic [7:0] rdData;
    logic [`DPM_DATA_MSB:0] sample;
    logic sampleValid;
    logic [31:0] prdata;
  } dpm_host_state_t;

endpackage

//--- pkg/dpm_if.sv
// Pins between the converter and the logic that feeds it
`timescale 1ns/1ps
`include "dpm_map.svh"
interface dpm_if;
  logic modeSelect;
  logic clockTypeOrSerialClock;
  logic powerdownOrChipSelect;
  logic sdioHostOut;
  logic sdioHostOe;
  logic sdioDevOut;
  logic sdioDevOe;
  logic sdioLevel;
  logic [`DPM_DATA_MSB:0] sample;
  logic sampleValid;
  logic sampleReady;

  // Shared format/data wire; weak pull-up when nobody drives
  assign sdioLevel = sdioHostOe ? sdioHostOut : (sdioDevOe ? sdioDevOut : 1'b1);

  modport dev (
    input modeSelect, clockTypeOrSerialClock, powerdownOrChipSelect, sdioLevel,
    input sample, sampleValid,
    output sdioDevOut, sdioDevOe, sampleReady
  );
  modport host (
    output modeSelect, clockTypeOrSerialClock, powerdownOrChipSelect,
    output sdioHostOut, sdioHostOe, sample, sampleValid,
    input sdioLevel, sampleReady
  );
endinterface

//--- src/dpm_device.sv
// Converter end: pin decode, serial registers, sample buffer and code conversion
`timescale 1ns/1ps
`include "dpm_map.svh"

// ****************************************
// Sample buffer
// ****************************************
module dpm_fifo #(
  parameter int WIDTH = `DPM_DATA_W,
  parameter int DEPTH = `DPM_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrIdx;
    logic [AW-1:0] rdIdx;
    logic [AW:0] count;
  } dpm_fifo_state_t;

  dpm_fifo_state_t s;
  dpm_fifo_state_t next_s;
  logic push;
  logic pop;

  assign inReady = (s.count != DEPTH[AW:0]);
  assign outValid = (s.count != '0);
  assign outData = s.mem[s.rdIdx];

  always_comb begin
    next_s = s;
    push = inValid && inReady;
    pop = outValid && outReady;
    if (push) begin
      next_s.mem[s.wrIdx] = inData;
      next_s.wrIdx = s.wrIdx + 1'b1;
    end
    if (pop) begin
      next_s.rdIdx = s.rdIdx + 1'b1;
    end
    if (push && !pop) begin
      next_s.count = s.count + 1'b1;
    end else if (pop && !push) begin
      next_s.count = s.count - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// ****************************************
// Converter control end
// ****************************************
module dpm_device (
  input wire logic sys_clk,
  input wire logic rst_b,
  dpm_if.dev bus,
  output logic [`DPM_DATA_MSB:0] trueCurrentOutput,
  output logic [`DPM_DATA_MSB:0] complementCurrentOutput,
  output logic powerDown,
  output logic singleEndedClock,
  output logic twosComplement,
  output logic pinMode
);
  dpm_pkg::dpm_dev_state_t s;
  dpm_pkg::dpm_dev_state_t next_s;
  logic [`DPM_DATA_MSB:0] fifoData;
  logic fifoValid;
  logic sclkRise;
  logic sclkFall;
  logic selected;
  logic [7:0] readValue;
  logic [`DPM_DATA_MSB:0] code;

  // Sleep stalls draining so the buffer fills and pushes back on the feeder
  dpm_fifo #(
    .WIDTH(`DPM_DATA_W),
    .DEPTH(`DPM_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .inData(bus.sample),
    .inValid(bus.sampleValid),
    .inReady(bus.sampleReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(!powerDown)
  );

  // ****************************************
  // Pin decode
  // ****************************************
  assign pinMode = s.modeSync[1];
  assign twosComplement = pinMode ? s.sdioSync[1] : s.ctrl[`DPM_SCTRL_TWOS];
  assign singleEndedClock = pinMode ? !s.sclkSync[1] : s.ctrl[`DPM_SCTRL_SE];
  assign powerDown = pinMode ? s.csbSync[1] : s.ctrl[`DPM_SCTRL_PD];
  assign selected = !pinMode && !s.csbSync[1];
  assign sclkRise = !pinMode && s.sclkSync[1] && !s.sclkSync[2];
  assign sclkFall = !pinMode && !s.sclkSync[1] && s.sclkSync[2];

  assign bus.sdioDevOut = s.rdBit;
  assign bus.sdioDevOe = s.rdOe;
  assign trueCurrentOutput = s.trueCode;
  assign complementCurrentOutput = s.compCode;

  always_comb begin
    readValue = 8'h00;
    if ({s.shiftIn[5:0], s.sdioSync[1]} == `DPM_SREG_CTRL) begin
      readValue = s.ctrl;
    end else if ({s.shiftIn[5:0], s.sdioSync[1]} == `DPM_SREG_STAT) begin
      readValue = {5'h00, fifoValid, twosComplement, powerDown};
    end
  end

  // Straight binary passes through; twos complement flips the sign bit
  always_comb begin
    code = fifoData;
    if (twosComplement) begin
      code[`DPM_DATA_MSB] = !fifoData[`DPM_DATA_MSB];
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.modeSync = {s.modeSync[0], bus.modeSelect};
    next_s.sclkSync = {s.sclkSync[1:0], bus.clockTypeOrSerialClock};
    next_s.csbSync = {s.csbSync[0], bus.powerdownOrChipSelect};
    next_s.sdioSync = {s.sdioSync[0], bus.sdioLevel};
    next_s.modePrev = pinMode;

    if (!selected) begin
      next_s.ser = dpm_pkg::DS_IDLE;
      next_s.bitCnt = 4'h0;
      next_s.rdOe = 1'b0;
    end else begin
      case (s.ser)
        dpm_pkg::DS_IDLE: begin
          next_s.ser = dpm_pkg::DS_HEAD;
          next_s.bitCnt = 4'h0;
        end
        dpm_pkg::DS_HEAD: begin
          if (sclkRise) begin
            next_s.shiftIn = {s.shiftIn[13:0], s.sdioSync[1]};
            next_s.bitCnt = s.bitCnt + 4'h1;
            if (s.bitCnt == `DPM_HEAD_LAST) begin
              if (s.shiftIn[6]) begin
                next_s.ser = dpm_pkg::DS_RDATA;
                next_s.outShift = readValue;
              end else begin
                next_s.ser = dpm_pkg::DS_WDATA;
              end
            end
          end
        end
        dpm_pkg::DS_WDATA: begin
          if (sclkRise) begin
            next_s.shiftIn = {s.shiftIn[13:0], s.sdioSync[1]};
            next_s.bitCnt = s.bitCnt + 4'h1;
            if (s.bitCnt == `DPM_FRAME_LAST) begin
              next_s.ser = dpm_pkg::DS_END;
              if (s.shiftIn[13:7] == `DPM_SREG_CTRL) begin
                next_s.ctrl = {s.shiftIn[6:0], s.sdioSync[1]};
              end
            end
          end
        end
        dpm_pkg::DS_RDATA: begin
          if (sclkFall) begin
            next_s.rdOe = 1'b1;
            next_s.rdBit = s.outShift[7];
            next_s.outShift = {s.outShift[6:0], 1'b0};
          end
          if (sclkRise) begin
            next_s.bitCnt = s.bitCnt + 4'h1;
            if (s.bitCnt == `DPM_FRAME_LAST) begin
              next_s.ser = dpm_pkg::DS_END;
            end
          end
        end
        dpm_pkg::DS_END: begin
          // Extra clocks inside one select are ignored until it rises
          next_s.rdOe = 1'b0;
        end
        default: begin
          next_s.ser = dpm_pkg::DS_IDLE;
        end
      endcase
    end

    // A rising edge on the mode pin wins over any serial write
    if (pinMode && !s.modePrev) begin
      next_s.ctrl = `DPM_SCTRL_DEF;
      next_s.ser = dpm_pkg::DS_IDLE;
      next_s.rdOe = 1'b0;
    end

    // Powered down: no current on either output
    if (powerDown) begin
      next_s.trueCode = '0;
      next_s.compCode = '0;
    end else if (fifoValid) begin
      next_s.trueCode = code;
      next_s.compCode = ~code;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

//--- src/dpm_host.sv
// Feeding end: APB registers driving the strap, serial and sample pins
`timescale 1ns/1ps
`include "dpm_map.svh"
module dpm_host (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  dpm_if.host bus
);
  dpm_pkg::dpm_host_state_t s;
  dpm_pkg::dpm_host_state_t next_s;
  logic serialMode;
  logic access;
  logic mapped;

  // ****************************************
  // Pins
  // ****************************************
  assign serialMode = !s.pins[`DPM_PINS_MODE];
  assign bus.modeSelect = s.pins[`DPM_PINS_MODE];
  assign bus.clockTypeOrSerialClock = serialMode ? s.sclk : s.pins[`DPM_PINS_CLK];
  assign bus.powerdownOrChipSelect = serialMode ? s.csb : s.pins[`DPM_PINS_SLEEP];
  assign bus.sdioHostOut = serialMode ? s.sdoBit : s.pins[`DPM_PINS_FMT];
  assign bus.sdioHostOe = serialMode ? s.sdoOe : 1'b1;
  assign bus.sample = s.sample;
  assign bus.sampleValid = s.sampleValid;

  // ****************************************
  // APB slave
  // ****************************************
  assign access = psel && penable;
  assign mapped = (paddr == `DPM_APB_PINS) || (paddr == `DPM_APB_CMD) ||
                  (paddr == `DPM_APB_STAT) || (paddr == `DPM_APB_SAMPLE);
  assign prdata = s.prdata;
  assign pslverr = access && !mapped;

  // Busy engine or unsent sample holds the access phase
  always_comb begin
    pready = 1'b1;
    if (pwrite && paddr == `DPM_APB_CMD && s.ser == dpm_pkg::HS_RUN) begin
      pready = 1'b0;
    end else if (pwrite && paddr == `DPM_APB_SAMPLE && s.sampleValid) begin
      pready = 1'b0;
    end
  end

  always_comb begin
    next_s = s;
    next_s.sdioSync = {s.sdioSync[0], bus.sdioLevel};
    if (s.sampleValid && bus.sampleReady) begin
      next_s.sampleValid = 1'b0;
    end

    if (psel && !penable) begin
      case (paddr)
        `DPM_APB_PINS: next_s.prdata = {28'h0000000, s.pins};
        `DPM_APB_STAT: next_s.prdata = {16'h0000, s.rdData, 7'h00, s.ser == dpm_pkg::HS_RUN};
        default: next_s.prdata = 32'h00000000;
      endcase
    end

    case (s.ser)
      dpm_pkg::HS_IDLE: begin
        if (access && pready && pwrite && paddr == `DPM_APB_CMD) begin
          next_s.ser = dpm_pkg::HS_RUN;
          next_s.cmd = pwdata[15:0];
          next_s.isRead = pwdata[`DPM_FRAME_RD];
          next_s.sdoBit = pwdata[`DPM_FRAME_RD];
          next_s.sdoOe = 1'b1;
          next_s.csb = 1'b0;
          next_s.sclk = 1'b0;
          next_s.div = 4'h0;
          next_s.bitCnt = 4'h0;
        end
      end
      dpm_pkg::HS_RUN: begin
        next_s.div = s.div + 4'h1;
        if (s.div == `DPM_SCLK_HALF) begin
          next_s.div = 4'h0;
          next_s.sclk = !s.sclk;
          if (!s.sclk) begin
            if (s.isRead && s.bitCnt > `DPM_HEAD_LAST) begin
              next_s.rdData = {s.rdData[6:0], s.sdioSync[1]};
            end
          end else if (s.bitCnt == `DPM_FRAME_LAST) begin
            next_s.ser = dpm_pkg::HS_IDLE;
            next_s.csb = 1'b1;
            next_s.sdoOe = 1'b1;
          end else begin
            next_s.bitCnt = s.bitCnt + 4'h1;
            next_s.cmd = {s.cmd[14:0], 1'b0};
            next_s.sdoBit = s.cmd[14];
            // Let go of the data line while the converter answers a read
            next_s.sdoOe = !(s.isRead && s.bitCnt >= `DPM_HEAD_LAST);
          end
        end
      end
      default: begin
        next_s.ser = dpm_pkg::HS_IDLE;
      end
    endcase

    if (access && pready && pwrite) begin
      if (paddr == `DPM_APB_PINS) begin
        next_s.pins = pwdata[3:0];
      end else if (paddr == `DPM_APB_SAMPLE) begin
        next_s.sample = pwdata[`DPM_DATA_MSB:0];
        next_s.sampleValid = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.pins <= `DPM_PINS_RST;
      s.csb <= 1'b1;
    end else begin
      s <= next_s;
    end
  end
endmodule

//--- tb/dpm_props.sv
// Checker watching the pins between the converter and its feeding logic
`timescale 1ns/1ps
`include "dpm_map.svh"
module dpm_props (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic modeSelect,
  input wire logic clockTypeOrSerialClock,
  input wire logic powerdownOrChipSelect,
  input wire logic sdioHostOut,
  input wire logic sdioHostOe,
  input wire logic sdioDevOut,
  input wire logic sdioDevOe,
  input wire logic sdioLevel,
  input wire logic [`DPM_DATA_MSB:0] sample,
  input wire logic sampleValid,
  input wire logic sampleReady
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // ****************************************
  // Serial clock edges per frame
  // ****************************************
  logic [4:0] edgeCnt;
  logic sclkPrev;
  // Cleared in pin mode too, where the clock pin is a strap that may toggle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      edgeCnt <= 5'h00;
      sclkPrev <= 1'b0;
    end else begin
      sclkPrev <= clockTypeOrSerialClock;
      if (powerdownOrChipSelect || modeSelect) begin
        edgeCnt <= 5'h00;
      end else if (clockTypeOrSerialClock && !sclkPrev) begin
        edgeCnt <= edgeCnt + 5'h01;
      end
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  property p_no_fight;
    !(sdioHostOe && sdioDevOe);
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive data pin");
  property p_dev_quiet_pin;
    modeSelect [*6] |-> !sdioDevOe;
  endproperty
  a_dev_quiet_pin: assert property (p_dev_quiet_pin) else $error("device drives in pin mode");
  property p_dev_needs_sel;
    powerdownOrChipSelect [*6] |-> !sdioDevOe;
  endproperty
  a_dev_needs_sel: assert property (p_dev_needs_sel) else $error("device drives unselected");
  property p_strap_driven;
    modeSelect && $past(modeSelect) |-> sdioHostOe;
  endproperty
  a_strap_driven: assert property (p_strap_driven) else $error("format strap floats");
  property p_sclk_half;
    $rose(clockTypeOrSerialClock) && !modeSelect && !powerdownOrChipSelect
      |-> clockTypeOrSerialClock [*8];
  endproperty
  a_sclk_half: assert property (p_sclk_half) else $error("serial clock high too short");
  property p_sclk_idle;
    powerdownOrChipSelect && $past(powerdownOrChipSelect) && !modeSelect && !$past(modeSelect)
      |-> $stable(clockTypeOrSerialClock);
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock moves outside frame");
  property p_frame_bits;
    // A strap-to-serial switch lifts the select line with no frame behind it
    $rose(powerdownOrChipSelect) && !modeSelect && !$past(modeSelect) |-> edgeCnt == 5'h10;
  endproperty
  a_frame_bits: assert property (p_frame_bits) else $error("frame edge count wrong");
  property p_valid_hold;
    sampleValid && !sampleReady |=> sampleValid && $stable(sample);
  endproperty
  a_valid_hold: assert property (p_valid_hold) else $error("sample dropped while stalled");
  c_frame: cover property ($rose(powerdownOrChipSelect) && !modeSelect && !$past(modeSelect));
  c_read: cover property ($rose(sdioDevOe));
  c_stall: cover property (sampleValid && !sampleReady);
  c_dev_zero: cover property (sdioDevOe && !sdioDevOut && !sdioLevel);
  c_host_one: cover property (!modeSelect && sdioHostOe && sdioHostOut && sdioLevel);
endmodule

//--- tb/tb.sv
// Testbench joining both converter control ends over their pin interface
`timescale 1ns/1ps
`include "dpm_map.svh"
module tb;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [`DPM_DATA_MSB:0] trueCurrentOutput;
  logic [`DPM_DATA_MSB:0] complementCurrentOutput;
  logic powerDown;
  logic singleEndedClock;
  logic twosComplement;
  logic pinMode;
  logic [31:0] rdVal;
  logic errBit;
  logic [7:0] serByte;
  logic [3:0] tPins [5] = '{4'h1, 4'h1, 4'h1, 4'h3, 4'h3};
  logic [13:0] tIn [5] = '{14'h3FFF, 14'h0000, 14'h2001, 14'h2001, 14'h1FFF};
  logic [13:0] tOut [5] = '{14'h3FFF, 14'h0000, 14'h2001, 14'h0001, 14'h3FFF};
  int errorCnt = 0;
  int comparisons = 0;

  dpm_if i_dpm_if ();
  dpm_host i_dpm_host (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(i_dpm_if));
  dpm_device i_dpm_device (.sys_clk(sys_clk), .rst_b(rst_b), .bus(i_dpm_if),
    .trueCurrentOutput(trueCurrentOutput), .complementCurrentOutput(complementCurrentOutput),
    .powerDown(powerDown), .singleEndedClock(singleEndedClock),
    .twosComplement(twosComplement), .pinMode(pinMode));
  dpm_props i_dpm_props (.sys_clk(sys_clk), .rst_b(rst_b), .modeSelect(i_dpm_if.modeSelect),
    .clockTypeOrSerialClock(i_dpm_if.clockTypeOrSerialClock),
    .powerdownOrChipSelect(i_dpm_if.powerdownOrChipSelect),
    .sdioHostOut(i_dpm_if.sdioHostOut), .sdioHostOe(i_dpm_if.sdioHostOe),
    .sdioDevOut(i_dpm_if.sdioDevOut), .sdioDevOe(i_dpm_if.sdioDevOe),
    .sdioLevel(i_dpm_if.sdioLevel), .sample(i_dpm_if.sample),
    .sampleValid(i_dpm_if.sampleValid), .sampleReady(i_dpm_if.sampleReady));

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Idle cycle at the end keeps two requests from sharing a time step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 1000) begin
      @(posedge sys_clk);
      n++;
    end
    rdVal = prdata;
    errBit = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 1000) begin
      errorCnt++;
      give_verdict();
    end
    @(posedge sys_clk);
  endtask

  // Strap pins, then let them pass the device's synchronisers
  task automatic pins(input logic [3:0] p);
    apb(1'b1, `DPM_APB_PINS, {28'h0000000, p});
    repeat (5) @(posedge sys_clk);
  endtask

  task automatic ser(input logic rd, input logic [6:0] a, input logic [7:0] d);
    int n;
    n = 0;
    apb(1'b1, `DPM_APB_CMD, {16'h0000, rd, a, d});
    apb(1'b0, `DPM_APB_STAT, 32'h00000000);
    while (rdVal[0] !== 1'b0 && n < 200) begin
      apb(1'b0, `DPM_APB_STAT, 32'h00000000);
      n++;
    end
    if (n == 200) begin
      errorCnt++;
      give_verdict();
    end
    serByte = rdVal[15:8];
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, `DPM_APB_PINS, 32'h00000000);
    chk(rdVal, 32'h00000001);
    chk(32'(pinMode), 32'h00000001);
    chk(32'(trueCurrentOutput), 32'h00000000);
    apb(1'b0, 12'h010, 32'h00000000);
    chk({rdVal[30:0], errBit}, 32'h00000001);
    $display("test reset done");
    for (int p = 0; p < 8; p++) begin
      pins({p[2:0], 1'b1});
      chk(32'(twosComplement), 32'(p[0]));
      chk(32'(singleEndedClock), 32'(!p[1]));
      chk(32'(powerDown), 32'(p[2]));
    end
    $display("test strap decode done");
    for (int i = 0; i < 5; i++) begin
      pins(tPins[i]);
      apb(1'b1, `DPM_APB_SAMPLE, {18'h00000, tIn[i]});
      repeat (4) @(posedge sys_clk);
      chk(32'(trueCurrentOutput), {18'h00000, tOut[i]});
      chk(32'(complementCurrentOutput), {18'h00000, ~tOut[i]});
    end
    $display("test conversion done");
    pins(4'h9);
    chk({trueCurrentOutput, complementCurrentOutput}, 32'h00000000);
    for (int k = 1; k <= 17; k++) begin
      apb(1'b1, `DPM_APB_SAMPLE, 32'(k));
    end
    chk(32'(i_dpm_if.sampleReady), 32'h00000000);
    pins(4'h1);
    repeat (30) @(posedge sys_clk);
    chk(32'(i_dpm_if.sampleReady), 32'h00000001);
    chk(32'(trueCurrentOutput), 32'h00000011);
    $display("test buffer done");
    pins(4'h0);
    chk(32'(pinMode), 32'h00000000);
    ser(1'b0, 7'h00, 8'h07);
    chk({29'h0, singleEndedClock, twosComplement, powerDown}, 32'h00000007);
    ser(1'b1, 7'h00, 8'h00);
    chk(32'(serByte), 32'h00000007);
    ser(1'b1, 7'h01, 8'h00);
    chk(32'(serByte), 32'h00000003);
    ser(1'b0, 7'h02, 8'h00);
    ser(1'b0, 7'h01, 8'h00);
    ser(1'b1, 7'h00, 8'h00);
    chk(32'(serByte), 32'h00000007);
    pins(4'h1);
    chk(32'(powerDown), 32'h00000000);
    pins(4'h0);
    ser(1'b1, 7'h00, 8'h00);
    chk(32'(serByte), 32'h00000000);
    $display("test serial done");
    give_verdict();
  end
endmodule
